// >>> logic/bpf_ctrl.sv
// Ballast protection, fault latch and PFC control with AXI4-Lite registers
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
//
// Operation
// - Start oscillating only with supply, line sense good and lamp sense low.
// - Line sense low during operation stops the oscillator.
// - Line sense recovery restarts the sequence from the beginning.
// - Lamp sense high in any mode: oscillator off, gates low, micropower.
// - Lamp sense back near ground after removal restarts the sequence.
// - In run, lamp sense outside the 1V to 3V window shuts down.
// - Any bridge-current fault sets fault latch and shuts everything down.
// - Overcurrent is checked every cycle, never averaged; undercurrent is checked only at bottom gate falling edges.
// - Overcurrent comparison is active only after preheat ends.
// - Undercurrent comparison is active from the start of run mode.
// - Undercurrent result is sampled at each falling edge of bottom gate.
// - PFC gate stays off until preheat mode begins.
// - First PFC pulse after enable uses the minimum on time.
// - Gain: max until 3V, nominal until 4V, max until run.
// - Bus overvoltage blocks PFC turn-on until feedback falls to 4.0V.
// - PFC turns on only for the first pulse after enable, after a zero-cross or on the watchdog pulse.
// - Watchdog pulses PFC after 500ms without zero-cross, restarts on one.
// - Fault latch clears on lamp sense high (lamp removal) or supply lockout.
// - Preheat node at 5.1V moves ignition to run, enabling run checks.
module bpf_ctrl #(
	parameter int unsigned WDOG_CYCLES = bpf_pkg::WDOG_CYCLES
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire bpf_pkg::bpf_cmp_t cmp_in,
	input  wire logic             osc_bottom_in,
	input  wire logic             osc_upper_in,
	output logic                  bottom_gate_drive,
	output logic                  upper_gate_drive,
	output logic                  pfc_gate_drive,
	output logic                  error_amp_gain,
	output logic                  micropower,
	output logic                  run_mode,
	output logic                  fault_latched,
	input  wire logic [3:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [3:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready
);

	typedef struct packed {
		bpf_pkg::bpf_mode_t mode;
		bpf_pkg::bpf_gain_t gain;
		logic               gain_max;
		logic               ov_block;
		logic               pfc_on;
		logic               first_pulse;
		logic [7:0]         on_cnt;
		logic               fault_latch;
		logic               zx_prev;
		logic               bottom_gate;
		logic               upper_gate;
		logic               pfc_allow;
		logic               restart;
		logic [3:0]         aw_addr;
		logic               aw_have;
		logic [31:0]        w_data;
		logic [3:0]         w_strb;
		logic               w_have;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
	} bpf_ctrl_state_t;

	bpf_ctrl_state_t   s_reg;
	bpf_ctrl_state_t   s_next;
	bpf_pkg::bpf_cmp_t c;
	logic              kick;
	logic              zx_rise;
	logic              bottom_fall;
	logic              start_ok;
	logic              wdog_en;

	function automatic logic is_active(input bpf_pkg::bpf_mode_t m);
		is_active = (m == bpf_pkg::ST_PREHEAT) ||
			(m == bpf_pkg::ST_IGNITION) || (m == bpf_pkg::ST_RUN);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Comparator synchroniser and watchdog
	bpf_sync #(
		.W        (bpf_pkg::CMP_W)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.async_in (cmp_in),
		.sync_out (c)
	);

	bpf_watchdog #(
		.CYCLES   (WDOG_CYCLES)
	) u_wdog (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.enable   (wdog_en),
		.zx_pulse (zx_rise),
		.kick     (kick)
	);

	assign zx_rise  = c.inductor_zero_cross & ~s_reg.zx_prev;
	assign wdog_en  = is_active(s_reg.mode) & s_reg.pfc_allow & ~s_reg.pfc_on;
	assign start_ok = c.supply_above_start & c.line_sense_ok &
		c.lamp_sense_start_ok;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic pfc_en;
		logic fault_now;
		pfc_en      = 1'b0;
		fault_now   = 1'b0;
		s_next      = s_reg;
		s_next.zx_prev = c.inductor_zero_cross;
		s_next.restart = 1'b0;
		bottom_fall = s_reg.bottom_gate & ~osc_bottom_in;

		// Mode sequence and protection
		if (c.bridge_over_cur && s_reg.mode != bpf_pkg::ST_PREHEAT) begin
			fault_now = 1'b1;
		end
		if (s_reg.mode == bpf_pkg::ST_RUN) begin
			if (bottom_fall && c.bridge_under_cur) begin
				fault_now = 1'b1;
			end
			if (c.lamp_win_low || c.lamp_win_high) begin
				fault_now = 1'b1;
			end
		end
		case (s_reg.mode)
			bpf_pkg::ST_IDLE: begin
				if (start_ok && !c.supply_below_lockout) begin
					s_next.mode = bpf_pkg::ST_PREHEAT;
				end
			end
			bpf_pkg::ST_PREHEAT,
			bpf_pkg::ST_IGNITION,
			bpf_pkg::ST_RUN: begin
				if (c.supply_below_lockout || s_reg.restart) begin
					s_next.mode = bpf_pkg::ST_IDLE;
				end else if (c.lamp_sense_high) begin
					s_next.mode = bpf_pkg::ST_LAMP_OUT;
				end else if (!c.line_sense_ok) begin
					s_next.mode = bpf_pkg::ST_IDLE;
				end else if (fault_now) begin
					s_next.mode        = bpf_pkg::ST_FAULT;
					s_next.fault_latch = 1'b1;
				end else if (s_reg.mode == bpf_pkg::ST_PREHEAT &&
					c.preheat_done) begin
					s_next.mode = bpf_pkg::ST_IGNITION;
				end else if (s_reg.mode == bpf_pkg::ST_IGNITION &&
					c.preheat_run) begin
					s_next.mode = bpf_pkg::ST_RUN;
				end
			end
			bpf_pkg::ST_FAULT: begin
				if (c.lamp_sense_high) begin
					s_next.mode = bpf_pkg::ST_LAMP_OUT;
				end
			end
			bpf_pkg::ST_LAMP_OUT: begin
				s_next.fault_latch = 1'b0;
				if (c.lamp_sense_start_ok) begin
					s_next.mode = bpf_pkg::ST_IDLE;
				end
			end
			default: begin
				s_next.mode = bpf_pkg::ST_IDLE;
			end
		endcase
		if (c.supply_below_lockout) begin
			s_next.mode        = bpf_pkg::ST_IDLE;
			s_next.fault_latch = 1'b0;
		end

		// Gate outputs follow the oscillator only while active
		s_next.bottom_gate = osc_bottom_in & is_active(s_next.mode);
		s_next.upper_gate  = osc_upper_in & is_active(s_next.mode);

		// Bus overvoltage hysteresis
		if (c.bus_fb_ov) begin
			s_next.ov_block = 1'b1;
		end else if (!c.bus_fb_4v) begin
			s_next.ov_block = 1'b0;
		end

		// PFC switching
		pfc_en = is_active(s_next.mode) & s_reg.pfc_allow;
		if (!pfc_en) begin
			s_next.pfc_on      = 1'b0;
			s_next.first_pulse = 1'b1;
			s_next.on_cnt      = 8'h00;
		end else if (s_reg.pfc_on) begin
			if (s_reg.on_cnt != bpf_pkg::PFC_MIN_ON_LAST) begin
				s_next.on_cnt = s_reg.on_cnt + 8'h01;
			end else if (s_reg.first_pulse || c.pfc_ontime_end) begin
				s_next.pfc_on      = 1'b0;
				s_next.first_pulse = 1'b0;
			end
		end else if (!s_next.ov_block &&
			(s_reg.first_pulse || zx_rise || kick)) begin
			s_next.pfc_on = 1'b1;
			s_next.on_cnt = 8'h00;
		end

		// Error amplifier gain schedule
		if (!is_active(s_next.mode)) begin
			s_next.gain = bpf_pkg::GS_RISE;
		end else begin
			case (s_reg.gain)
				bpf_pkg::GS_RISE: begin
					if (c.bus_fb_3v) begin
						s_next.gain = bpf_pkg::GS_NOM;
					end
				end
				bpf_pkg::GS_NOM: begin
					if (c.bus_fb_4v) begin
						s_next.gain = bpf_pkg::GS_HOLD;
					end
				end
				default: begin
					s_next.gain = bpf_pkg::GS_HOLD;
				end
			endcase
		end
		s_next.gain_max = s_next.mode != bpf_pkg::ST_RUN &&
			s_next.gain != bpf_pkg::GS_NOM;

		// AXI4-Lite write
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_addr = s_axi_awaddr;
			s_next.aw_have = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
			s_next.w_have = 1'b1;
		end
		if (s_reg.aw_have && s_reg.w_have) begin
			s_next.aw_have = 1'b0;
			s_next.w_have  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = bpf_pkg::RESP_SLVERR;
			if (s_reg.aw_addr == bpf_pkg::ADDR_CTRL) begin
				s_next.bresp = bpf_pkg::RESP_OKAY;
				if (s_reg.w_strb[0]) begin
					s_next.pfc_allow =
						s_reg.w_data[bpf_pkg::CTRL_PFC_ALLOW];
					s_next.restart   =
						s_reg.w_data[bpf_pkg::CTRL_RESTART];
				end
			end
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end

		// AXI4-Lite read
		if (s_axi_arvalid && s_axi_arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp  = bpf_pkg::RESP_OKAY;
			s_next.rdata  = 32'h0000_0000;
			case (s_axi_araddr)
				bpf_pkg::ADDR_CTRL: begin
					s_next.rdata[bpf_pkg::CTRL_PFC_ALLOW] = s_reg.pfc_allow;
				end
				bpf_pkg::ADDR_STATUS: begin
					s_next.rdata[5:0] = s_reg.mode;
					s_next.rdata[bpf_pkg::ST_FAULT_LATCH] = s_reg.fault_latch;
					s_next.rdata[bpf_pkg::ST_GAIN_MAX]    = s_reg.gain_max;
					s_next.rdata[bpf_pkg::ST_OV_BLOCK]    = s_reg.ov_block;
					s_next.rdata[bpf_pkg::ST_PFC_ON]      = s_reg.pfc_on;
					s_next.rdata[bpf_pkg::ST_OSC_ON]      =
						is_active(s_reg.mode);
				end
				default: begin
					s_next.rresp = bpf_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_reg           <= '0;
			s_reg.mode      <= bpf_pkg::ST_IDLE;
			s_reg.gain      <= bpf_pkg::GS_RISE;
			s_reg.gain_max  <= 1'b1;
			s_reg.first_pulse <= 1'b1;
			s_reg.pfc_allow <= bpf_pkg::CTRL_ALLOW_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign bottom_gate_drive = s_reg.bottom_gate;
	assign upper_gate_drive  = s_reg.upper_gate;
	assign pfc_gate_drive    = s_reg.pfc_on;
	assign error_amp_gain    = s_reg.gain_max;
	assign micropower        = ~is_active(s_reg.mode);
	assign run_mode          = s_reg.mode == bpf_pkg::ST_RUN;
	assign fault_latched     = s_reg.fault_latch;
	assign s_axi_awready     = ~s_reg.aw_have & ~s_reg.bvalid;
	assign s_axi_wready      = ~s_reg.w_have & ~s_reg.bvalid;
	assign s_axi_bvalid      = s_reg.bvalid;
	assign s_axi_bresp       = s_reg.bresp;
	assign s_axi_arready     = ~s_reg.rvalid;
	assign s_axi_rvalid      = s_reg.rvalid;
	assign s_axi_rdata       = s_reg.rdata;
	assign s_axi_rresp       = s_reg.rresp;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_gates_off_idle: assert property (
		!is_active(s_reg.mode) |-> !bottom_gate_drive && !upper_gate_drive)
		else $error("gate driven while not oscillating");
	a_start_needs_all: assert property (
		s_reg.mode == bpf_pkg::ST_IDLE ##1 s_reg.mode == bpf_pkg::ST_PREHEAT
		|-> $past(start_ok))
		else $error("started without all start conditions");
	a_lamp_high_off: assert property (
		is_active(s_reg.mode) && c.lamp_sense_high &&
		!c.supply_below_lockout && !s_reg.restart
		|=> s_reg.mode == bpf_pkg::ST_LAMP_OUT && micropower)
		else $error("lamp sense high did not shut down");
	a_line_low_idle: assert property (
		is_active(s_reg.mode) && !c.line_sense_ok && !c.lamp_sense_high
		|=> s_reg.mode == bpf_pkg::ST_IDLE)
		else $error("line undervoltage did not restart");
	a_lamp_return: assert property (
		s_reg.mode == bpf_pkg::ST_LAMP_OUT && c.lamp_sense_start_ok
		|=> s_reg.mode == bpf_pkg::ST_IDLE && !fault_latched)
		else $error("lamp reinsertion did not restart");
	a_supply_clears: assert property (
		c.supply_below_lockout |=> !fault_latched &&
		s_reg.mode == bpf_pkg::ST_IDLE)
		else $error("supply lockout did not clear fault");
	a_no_oc_preheat: assert property (
		s_reg.mode == bpf_pkg::ST_PREHEAT |=> s_reg.mode != bpf_pkg::ST_FAULT)
		else $error("fault taken during preheat");
	a_pfc_idle_off: assert property (
		!is_active(s_reg.mode) |-> !pfc_gate_drive)
		else $error("PFC switching before preheat");
	a_ov_blocks: assert property (
		s_reg.ov_block && c.bus_fb_4v && !pfc_gate_drive |=> !pfc_gate_drive)
		else $error("PFC turned on under overvoltage");
	a_pfc_on_cause: assert property (
		$rose(pfc_gate_drive) |-> $past(s_reg.first_pulse || zx_rise || kick))
		else $error("PFC turned on without zero-cross");
	a_min_on_time: assert property (
		$fell(pfc_gate_drive) |-> !is_active(s_reg.mode) ||
		!$past(s_reg.pfc_allow) ||
		$past(s_reg.on_cnt) == bpf_pkg::PFC_MIN_ON_LAST)
		else $error("PFC on time below minimum");
	a_gain_step: assert property (
		is_active(s_reg.mode) && s_reg.gain == bpf_pkg::GS_RISE &&
		c.bus_fb_3v && is_active(s_next.mode) |=> s_reg.gain == bpf_pkg::GS_NOM)
		else $error("gain did not drop at 3V");
	a_under_sample: assert property (
		s_reg.mode == bpf_pkg::ST_RUN && bottom_fall && c.bridge_under_cur &&
		c.line_sense_ok && !c.lamp_sense_high && !c.supply_below_lockout &&
		!s_reg.restart |=> s_reg.mode == bpf_pkg::ST_FAULT && fault_latched)
		else $error("undercurrent at gate fall not latched");

	c_reach_run: cover property (s_reg.mode == bpf_pkg::ST_RUN);
	c_fault: cover property (s_reg.mode == bpf_pkg::ST_FAULT);
	c_relamp: cover property (s_reg.mode == bpf_pkg::ST_LAMP_OUT ##1
		s_reg.mode == bpf_pkg::ST_IDLE);
	c_kick_on: cover property (kick ##1 pfc_gate_drive);

endmodule

// >>> logic/bpf_pkg.sv
// Shared constants and types of the ballast protection and PFC control block
package bpf_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_MHZ           = 125;
	localparam int WDOG_TIME_MS      = 500;
	localparam int WDOG_CYCLES       = WDOG_TIME_MS * CLK_MHZ * 1000;
	localparam int PFC_MIN_ON_NS     = 500;
	localparam int PFC_MIN_ON_CYCLES = (PFC_MIN_ON_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] PFC_MIN_ON_LAST = 8'(PFC_MIN_ON_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [3:0] ADDR_CTRL        = 4'h0;
	localparam logic [3:0] ADDR_STATUS      = 4'h4;
	localparam int         CTRL_PFC_ALLOW   = 0;
	localparam int         CTRL_RESTART     = 1;
	localparam logic       CTRL_ALLOW_RESET = 1'b1;
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLVERR      = 2'h2;
	localparam int         ST_FAULT_LATCH   = 6;
	localparam int         ST_GAIN_MAX      = 7;
	localparam int         ST_OV_BLOCK      = 8;
	localparam int         ST_PFC_ON        = 9;
	localparam int         ST_OSC_ON        = 10;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [5:0] {
		ST_IDLE     = 6'h01,
		ST_PREHEAT  = 6'h02,
		ST_IGNITION = 6'h04,
		ST_RUN      = 6'h08,
		ST_FAULT    = 6'h10,
		ST_LAMP_OUT = 6'h20
	} bpf_mode_t;

	typedef enum logic [2:0] {
		GS_RISE = 3'h1,
		GS_NOM  = 3'h2,
		GS_HOLD = 3'h4
	} bpf_gain_t;

	typedef struct packed {
		logic supply_above_start;
		logic supply_below_lockout;
		logic line_sense_ok;
		logic lamp_sense_high;
		logic lamp_sense_start_ok;
		logic lamp_win_low;
		logic lamp_win_high;
		logic bridge_over_cur;
		logic bridge_under_cur;
		logic preheat_done;
		logic preheat_run;
		logic bus_fb_3v;
		logic bus_fb_4v;
		logic bus_fb_ov;
		logic inductor_zero_cross;
		logic pfc_ontime_end;
	} bpf_cmp_t;

	localparam int CMP_W = $bits(bpf_cmp_t);

endpackage

// >>> logic/bpf_sync.sv
// Two-stage synchroniser for the comparator bundle
`timescale 1ns/100ps
module bpf_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} bpf_sync_state_t;

	bpf_sync_state_t s_reg;
	bpf_sync_state_t s_next;

	always_comb begin
		s_next      = s_reg;
		s_next.meta = async_in;
		s_next.sync = s_reg.meta;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_out = s_reg.sync;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_sync_two_stage: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(rst_n) && $past(rst_n, 2) |-> sync_out == $past(async_in, 2))
		else $error("synchroniser latency not two cycles");

endmodule

// >>> logic/bpf_watchdog.sv
// Zero-cross watchdog that forces a PFC turn-on pulse
`timescale 1ns/100ps
module bpf_watchdog #(
	parameter int unsigned CYCLES = bpf_pkg::WDOG_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic zx_pulse,
	output logic      kick
);

	typedef struct packed {
		logic [31:0] cnt;
		logic        kick;
	} bpf_wdog_state_t;

	bpf_wdog_state_t s_reg;
	bpf_wdog_state_t s_next;

	always_comb begin
		s_next      = s_reg;
		s_next.kick = 1'b0;
		if (!enable || zx_pulse) begin
			s_next.cnt = 32'h0;
		end else if (s_reg.cnt == 32'(CYCLES - 1)) begin
			s_next.cnt  = 32'h0;
			s_next.kick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign kick = s_reg.kick;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_kick_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
		zx_pulse |=> !kick ##1 !kick)
		else $error("watchdog fired right after a zero-cross");

	c_wdog_kick: cover property (@(posedge clk_sys) disable iff (!rst_n)
		kick);

endmodule

// >>> dv/bpf_stage_model.sv
// Power stage model: oscillator, PFC inductor and sense comparators
`timescale 1ns/100ps
module bpf_stage_model (
	input  wire logic              clk_sys,
	input  wire bpf_pkg::bpf_cmp_t lvl,
	input  wire logic              osc_en,
	input  wire logic              zx_en,
	input  wire logic [7:0]        half,
	input  wire logic              pfc_gate_drive,
	output bpf_pkg::bpf_cmp_t      cmp_in,
	output logic                   osc_bottom_in,
	output logic                   osc_upper_in
);
	int ph = 0;
	int on_cnt = 0;
	int off_cnt = 0;
	int hp;

	////////////////////////////////////////////////////////////////
	// Oscillator: bottom phase, dead time, upper phase, dead time
	assign hp = int'(half);
	always @(posedge clk_sys) begin
		ph <= (!osc_en || ph >= 4 * hp - 1) ? 0 : ph + 1;
		on_cnt <= pfc_gate_drive ? on_cnt + 1 : 0;
		off_cnt <= pfc_gate_drive ? 0 : off_cnt + 1;
	end
	assign osc_bottom_in = osc_en && ph < hp;
	assign osc_upper_in  = osc_en && ph >= 2 * hp && ph < 3 * hp;

	////////////////////////////////////////////////////////////////
	// Inductor current reaches zero some cycles after turn-off
	always_comb begin
		cmp_in = lvl;
		cmp_in.pfc_ontime_end = on_cnt >= 70;
		cmp_in.inductor_zero_cross = zx_en && off_cnt >= 12 && off_cnt < 15;
	end
endmodule

// >>> dv/tb_ballast_pfc_fault_protection.sv
// Self-checking bench of the ballast protection and PFC control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin \
	$display("ERROR %s expected %0h seen %0h", n, e, g); \
	miscompares++; end end
module tb_ballast_pfc_fault_protection;
	logic              clk_sys = 0;
	logic              rst_n = 0;
	bpf_pkg::bpf_cmp_t lvl = '0;
	bpf_pkg::bpf_cmp_t cmp;
	logic              osc_en = 1;
	logic              zx_en = 0;
	logic [7:0]        half = 8'h04;
	logic              ob, ou, bg, ug, pfc, gain, mp, run, flt;
	logic [3:0]        awaddr = 4'h0;
	logic [3:0]        araddr = 4'h0;
	logic [31:0]       wdata = 32'h0;
	logic              awvalid = 0, wvalid = 0, bready = 0;
	logic              arvalid = 0, rready = 0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp, rs;
	logic [31:0]       rdata, rd;
	int                miscompares = 0;
	int                tests_run = 0;
	int                cyc = 0;
	int                n;
	bpf_pkg::bpf_mode_t em = bpf_pkg::ST_IDLE;
	logic              ef = 0;

	always #4 clk_sys = ~clk_sys;

	bpf_stage_model i_bpf_stage_model (.clk_sys(clk_sys), .lvl(lvl),
		.osc_en(osc_en), .zx_en(zx_en), .half(half),
		.pfc_gate_drive(pfc), .cmp_in(cmp), .osc_bottom_in(ob),
		.osc_upper_in(ou));

	bpf_ctrl #(.WDOG_CYCLES(200)) i_bpf_ctrl (.clk_sys(clk_sys),
		.rst_n(rst_n), .cmp_in(cmp), .osc_bottom_in(ob), .osc_upper_in(ou),
		.bottom_gate_drive(bg), .upper_gate_drive(ug),
		.pfc_gate_drive(pfc), .error_amp_gain(gain), .micropower(mp),
		.run_mode(run), .fault_latched(flt), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	////////////////////////////////////////////////////////////////
	// Bus and measurement tasks
	task cy(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	task rd_reg(input logic [3:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk_sys); while (arready !== 1'b1);
		@(posedge clk_sys);
		arvalid <= 1'b0;
		do @(negedge clk_sys); while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		@(posedge clk_sys);
		rready <= 1'b0;
	endtask

	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 0;
		tw = 0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge clk_sys);
			ta = ta || awready === 1'b1;
			tw = tw || wready === 1'b1;
			@(posedge clk_sys);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1) @(negedge clk_sys);
		rs = bresp;
		@(posedge clk_sys);
		bready <= 1'b0;
	endtask

	task st;
		logic q;
		rd_reg(bpf_pkg::ADDR_STATUS);
		q = em inside {bpf_pkg::ST_IDLE, bpf_pkg::ST_FAULT,
			bpf_pkg::ST_LAMP_OUT};
		`CHK("mode", 6'(em), rd[5:0])
		`CHK("fault", ef, rd[6])
		`CHK("fault pin", ef, flt)
		`CHK("micropower", q, mp)
		`CHK("oscillating", !q, rd[10])
		`CHK("run", em == bpf_pkg::ST_RUN, run)
		`CHK("gates", 2'b00, {bg & mp, ug & mp})
	endtask

	task cnt_hi(input int k);
		n = 0;
		repeat (k) begin
			@(negedge clk_sys);
			n += int'(pfc === 1'b1);
		end
		@(posedge clk_sys);
	endtask

	task off_len;
		while (pfc === 1'b1) @(negedge clk_sys);
		n = 0;
		while (pfc !== 1'b1) begin
			@(negedge clk_sys);
			n++;
		end
		@(posedge clk_sys);
	endtask

	task finish_test;
		if (miscompares == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			finish_test;
		end
	end

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		n = $urandom(44);
		half = 8'(3 + $urandom % 5);
		cy(2);
		rst_n <= 1'b1;
		cy(3);
		st;
		`CHK("gain", 1'b1, gain)
		`CHK("pfc idle", 1'b0, pfc)
		rd_reg(4'h8);
		`CHK("rresp", bpf_pkg::RESP_SLVERR, rs)
		wr_reg(bpf_pkg::ADDR_STATUS, $urandom);
		`CHK("bresp", bpf_pkg::RESP_SLVERR, rs)
		rd_reg(bpf_pkg::ADDR_CTRL);
		`CHK("ctrl", 2'h1, rd[1:0])
		lvl.supply_above_start <= 1;
		lvl.line_sense_ok <= 1;
		cy(6);
		st;
		`CHK("pfc idle", 1'b0, pfc)
		lvl.lamp_sense_start_ok <= 1;
		em = bpf_pkg::ST_PREHEAT;
		while (pfc !== 1'b1) @(negedge clk_sys);
		n = 0;
		while (pfc === 1'b1) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK("min on", bpf_pkg::PFC_MIN_ON_CYCLES, n)
		n = 0;
		repeat (40) @(negedge clk_sys) n += int'(bg === 1'b1);
		`CHK("bottom on", 1'b1, n > 0)
		n = 0;
		repeat (40) @(negedge clk_sys) n += int'(ug === 1'b1);
		`CHK("upper on", 1'b1, n > 0)
		@(posedge clk_sys);
		lvl.bridge_over_cur <= 1;
		cy(6);
		st;
		lvl.bus_fb_3v <= 1;
		cy(6);
		`CHK("gain", 1'b0, gain)
		lvl.bus_fb_4v <= 1;
		cy(6);
		`CHK("gain", 1'b1, gain)
		lvl.preheat_done <= 1;
		em = bpf_pkg::ST_FAULT;
		ef = 1;
		cy(8);
		st;
		lvl.bridge_over_cur <= 0;
		lvl.preheat_done <= 0;
		lvl.lamp_sense_high <= 1;
		lvl.lamp_sense_start_ok <= 0;
		em = bpf_pkg::ST_LAMP_OUT;
		ef = 0;
		cy(6);
		st;
		lvl.lamp_sense_high <= 0;
		lvl.lamp_sense_start_ok <= 1;
		em = bpf_pkg::ST_PREHEAT;
		cy(6);
		st;
		lvl.preheat_done <= 1;
		em = bpf_pkg::ST_IGNITION;
		cy(6);
		lvl.line_sense_ok <= 0;
		em = bpf_pkg::ST_IDLE;
		cy(6);
		st;
		lvl.preheat_done <= 0;
		lvl.line_sense_ok <= 1;
		em = bpf_pkg::ST_PREHEAT;
		cy(6);
		st;
		lvl.preheat_done <= 1;
		lvl.preheat_run <= 1;
		em = bpf_pkg::ST_RUN;
		cy(8);
		st;
		`CHK("gain run", 1'b0, gain)
		osc_en <= 0;
		cy(4);
		lvl.bridge_under_cur <= 1;
		cy(20);
		st;
		osc_en <= 1;
		em = bpf_pkg::ST_FAULT;
		ef = 1;
		cy(4 * int'(half) + 6);
		st;
		lvl.bridge_under_cur <= 0;
		lvl.supply_below_lockout <= 1;
		em = bpf_pkg::ST_IDLE;
		ef = 0;
		cy(6);
		st;
		lvl.supply_below_lockout <= 0;
		em = bpf_pkg::ST_RUN;
		cy(12);
		st;
		lvl.lamp_sense_start_ok <= 0;
		wr_reg(bpf_pkg::ADDR_CTRL, 32'h3);
		em = bpf_pkg::ST_IDLE;
		cy(4);
		st;
		lvl.lamp_sense_start_ok <= 1;
		em = bpf_pkg::ST_RUN;
		cy(12);
		lvl.lamp_win_low <= 1;
		em = bpf_pkg::ST_FAULT;
		ef = 1;
		cy(6);
		st;
		lvl.lamp_win_low <= 0;
		lvl.supply_below_lockout <= 1;
		ef = 0;
		cy(6);
		lvl.supply_below_lockout <= 0;
		em = bpf_pkg::ST_RUN;
		cy(12);
		lvl.lamp_win_high <= 1;
		em = bpf_pkg::ST_FAULT;
		ef = 1;
		cy(6);
		st;
		lvl.supply_below_lockout <= 1;
		lvl.lamp_win_high <= 0;
		lvl.preheat_done <= 0;
		lvl.preheat_run <= 0;
		cy(6);
		lvl.supply_below_lockout <= 0;
		cy(10);
		off_len;
		`CHK("watchdog", 1'b1, n >= 195 && n <= 215)
		zx_en <= 1;
		off_len;
		`CHK("zero cross", 1'b1, n < 30)
		lvl.bus_fb_ov <= 1;
		cy(100);
		cnt_hi(400);
		`CHK("ov block", 0, n)
		lvl.bus_fb_ov <= 0;
		cnt_hi(300);
		`CHK("ov hysteresis", 0, n)
		lvl.bus_fb_4v <= 0;
		cnt_hi(300);
		`CHK("ov clear", 1'b1, n > 0)
		wr_reg(bpf_pkg::ADDR_CTRL, 32'h0);
		cy(100);
		cnt_hi(400);
		`CHK("pfc allow", 0, n)
		finish_test;
	end
endmodule
